// File: shared/shlp_pkg.sv
// constants shared by the serial host port, its program ram and the bench
// assumes nothing; imported by scope only (shlp_pkg::name)
`default_nettype none
package shlp_pkg;
  // synchroniser depth for pins sampled by ref_clk_i
  localparam int unsigned SYNC_STAGES   = 2;
  // register addresses on the serial port
  localparam logic [5:0]  CTRL_ADDR     = 6'h3F;
  localparam logic [5:0]  SIG_ADDR      = 6'h07;
  // loader control register layout and reset value
  localparam int unsigned LOADER_EN_POS = 2;
  localparam int unsigned RAM_EXEC_POS  = 3;
  localparam logic [7:0]  CTRL_MASK     = 8'h0C;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  // signature register defaults, overridable at the top
  localparam logic [7:0]  SIG_SEED      = 8'hA6;
  localparam logic [7:0]  SIG_POLY      = 8'h1D;
  // command byte layout: read/write flag first, then six address bits
  localparam logic [3:0]  CMD_RW_BIT    = 4'h0;
  localparam logic [3:0]  CMD_ADDR_LAST = 4'h6;
  localparam logic [3:0]  BYTE_LAST     = 4'h7;
  // program ram geometry
  localparam int unsigned RAM_AW        = 12;
  localparam int unsigned RAM_DW        = 8;
  localparam logic [12:0] RAM_DEPTH     = 13'h1000;
  localparam logic [12:0] FILL_RESET    = 13'h0000;
  // transaction phases
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CMD,
    ST_DATA,
    ST_WAIT
  } shlp_state_e;
endpackage
`default_nettype wire

// File: shared/shlp_ram_if.sv
// carrier between the serial port and its program ram
// assumes both ends run on ref_clk_i
`timescale 1ns/1ps
`default_nettype none
interface shlp_ram_if;
  logic                          we;
  logic [shlp_pkg::RAM_AW-1:0]   waddr;
  logic [shlp_pkg::RAM_DW-1:0]   wdata;
  logic [shlp_pkg::RAM_AW-1:0]   raddr;
  logic [shlp_pkg::RAM_DW-1:0]   rdata;
  modport writer (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem    (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// File: src/shlp_prog_ram.sv
// loadable program ram, one write port and one registered read port
// assumes a single clock; no reset on the array itself
`timescale 1ns/1ps
`default_nettype none
module shlp_prog_ram (
  input  wire logic   clk_i,
  shlp_ram_if.mem     ram
);
  localparam int unsigned DEPTH = 1 << shlp_pkg::RAM_AW;

  logic [shlp_pkg::RAM_DW-1:0] mem_q [DEPTH];
  logic [shlp_pkg::RAM_DW-1:0] rdata_q;

  // write from the loader, registered read for program fetch
  always_ff @(posedge clk_i) begin
    if (ram.we) begin
      mem_q[ram.waddr] <= ram.wdata;
    end
    rdata_q <= mem_q[ram.raddr];
  end

  assign ram.rdata = rdata_q;
endmodule
`default_nettype wire

// File: src/shlp_serial_port.sv
// serial host register port with program ram loader and signature
// assumes the host keeps cs_b_i low for one two-byte transaction at a time
// assumes sclk_i is slow enough for ref_clk_i to see every level (>= 3 clocks)
`timescale 1ns/1ps
`default_nettype none
// How it works
// - chip select fall samples serial clock; high picks lsb-first single-pin timing
// - single-pin timing receives and transmits on the shared pin, dedicated input unused
// - clock low at select fall: msb-first, shared pin transmits, dedicated pin receives
// - msb-first half duplex: host ignores output on writes, device ignores input on reads
// - each transaction is command/address byte then data byte under one select low
// - first eight clocks are the command byte, next eight are the data byte
// - select rise releases the shared pin, which stays released while select is high
// - data bytes go lsb first in single-pin timing, msb first otherwise
// - received bits sampled on clock rise, transmitted bits launched on clock fall
// - master clock runs continuously and free of the frame timing
// - loader mode is switched only by the enable bit of control register 3fh
// - loader mode writes not to 3fh fill ram at an internal address
// - reads in loader mode leave the fill address untouched
// - only the first 4096 fill writes reach ram; later ones are dropped
// - eight-bit misr signature is updated only by fill write data
// - clearing the loader enable bit resets signature and fill address
// - hardware reset also returns signature and fill address to ready
// - loader mode write to 3fh updates control, ram untouched, load kept unless the enable bit is cleared
// - loader mode read: address bit 5 set gives control, clear gives signature
// - run from ram by clearing loader enable with ram execute set
// - while reset is low the shared pin is released and logic is held
module shlp_serial_port #(
  parameter logic [7:0] MISR_POLY = shlp_pkg::SIG_POLY,
  parameter logic [7:0] MISR_SEED = shlp_pkg::SIG_SEED
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        cs_b_i,
  input  wire logic        sclk_i,
  input  wire logic        shared_serial_io_i,
  output var  logic        shared_serial_io_o,
  output var  logic        shared_serial_io_oe_o,
  input  wire logic        dedicated_serial_in_i,
  output var  logic        reg_wr_o,
  output var  logic [5:0]  reg_addr_o,
  output var  logic [7:0]  reg_wdata_o,
  input  wire logic [7:0]  reg_rdata_i,
  output var  logic        loader_enable_o,
  output var  logic        ram_execute_select_o,
  input  wire logic [11:0] prog_addr_i,
  output var  logic [7:0]  prog_data_o
);

  // pin order inside the synchroniser vectors
  localparam int unsigned P_CS   = 0;
  localparam int unsigned P_SCLK = 1;
  localparam int unsigned P_SIO  = 2;
  localparam int unsigned P_DIN  = 3;
  localparam int unsigned NPINS  = 4;

  logic [NPINS-1:0] pins;
  logic [NPINS-1:0] sync [shlp_pkg::SYNC_STAGES];
  logic [NPINS-1:0] prev;

  logic cs_s;
  logic sclk_s;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic rx_bit;

  shlp_pkg::shlp_state_e state;
  shlp_pkg::shlp_state_e next_state;
  logic        lsb_mode;
  logic        next_lsb_mode;
  logic [3:0]  bit_cnt;
  logic [3:0]  next_bit_cnt;
  logic        rd_cmd;
  logic        next_rd_cmd;
  logic [5:0]  cmd_addr;
  logic [5:0]  next_cmd_addr;
  logic [7:0]  rx_shift;
  logic [7:0]  next_rx_shift;
  logic [7:0]  tx_shift;
  logic [7:0]  next_tx_shift;
  logic        tx_bit;
  logic        next_tx_bit;
  logic        tx_oe;
  logic        next_tx_oe;
  logic [7:0]  ctrl;
  logic [7:0]  next_ctrl;
  logic [7:0]  sig;
  logic [7:0]  next_sig;
  logic [12:0] fill_cnt;
  logic [12:0] next_fill_cnt;
  logic        reg_wr;
  logic        next_reg_wr;
  logic [5:0]  reg_addr;
  logic [5:0]  next_reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  next_reg_wdata;
  logic        ram_we;
  logic        next_ram_we;
  logic [11:0] ram_waddr;
  logic [11:0] next_ram_waddr;
  logic [7:0]  ram_wdata;
  logic [7:0]  next_ram_wdata;

  shlp_ram_if ram ();

  // one misr step: shift, fold back the polynomial, mix in the data byte
  function automatic logic [7:0] misr_step(input logic [7:0] cur, input logic [7:0] d);
    misr_step = {cur[6:0], 1'b0} ^ (cur[7] ? MISR_POLY : 8'h00) ^ d;
  endfunction

  // byte returned by a read, chosen at the first data launch
  function automatic logic [7:0] read_mux(input logic       loader,
                                          input logic [5:0] addr,
                                          input logic [7:0] c,
                                          input logic [7:0] s,
                                          input logic [7:0] ext);
    if (loader) begin
      read_mux = addr[5] ? c : s;
    end else if (addr == shlp_pkg::CTRL_ADDR) begin
      read_mux = c;
    end else if (addr == shlp_pkg::SIG_ADDR) begin
      read_mux = s;
    end else begin
      read_mux = ext;
    end
  endfunction

  assign pins = {dedicated_serial_in_i, shared_serial_io_i, sclk_i, cs_b_i};

  // two-stage synchronisers for every pin, then one more stage for edges
  genvar g;
  generate
    for (g = 0; g < shlp_pkg::SYNC_STAGES; g++) begin : g_sync
      always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          sync[g] <= 4'h1;
        end else begin
          sync[g] <= (g == 0) ? pins : sync[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev <= 4'h1;
    end else begin
      prev <= sync[shlp_pkg::SYNC_STAGES-1];
    end
  end

  // edge detection on the settled pin levels
  assign cs_s      = sync[shlp_pkg::SYNC_STAGES-1][P_CS];
  assign sclk_s    = sync[shlp_pkg::SYNC_STAGES-1][P_SCLK];
  assign cs_fall   = prev[P_CS] & ~cs_s;
  assign cs_rise   = ~prev[P_CS] & cs_s;
  assign sclk_rise = ~prev[P_SCLK] & sclk_s;
  assign sclk_fall = prev[P_SCLK] & ~sclk_s;
  // receive pin depends on the timing picked at select fall
  assign rx_bit    = lsb_mode ? sync[shlp_pkg::SYNC_STAGES-1][P_SIO]
                              : sync[shlp_pkg::SYNC_STAGES-1][P_DIN];

  // transaction sequencing, register writes and loader next values
  always_comb begin
    logic [7:0] byte_in;
    logic [7:0] byte_out;
    byte_in        = lsb_mode ? {rx_bit, rx_shift[7:1]}
                              : {rx_shift[6:0], rx_bit};
    byte_out       = 8'h00;
    next_state     = state;
    next_lsb_mode  = lsb_mode;
    next_bit_cnt   = bit_cnt;
    next_rd_cmd    = rd_cmd;
    next_cmd_addr  = cmd_addr;
    next_rx_shift  = rx_shift;
    next_tx_shift  = tx_shift;
    next_tx_bit    = tx_bit;
    next_tx_oe     = tx_oe;
    next_ctrl      = ctrl;
    next_sig       = sig;
    next_fill_cnt  = fill_cnt;
    next_reg_wr    = 1'b0;
    next_reg_addr  = reg_addr;
    next_reg_wdata = reg_wdata;
    next_ram_we    = 1'b0;
    next_ram_waddr = ram_waddr;
    next_ram_wdata = ram_wdata;
    if (cs_s) begin
      // select high ends any transfer and releases the pin
      next_state = shlp_pkg::ST_IDLE;
      next_tx_oe = 1'b0;
    end else begin
      case (state)
        shlp_pkg::ST_IDLE: begin
          if (cs_fall) begin
            next_lsb_mode = sclk_s;
            next_bit_cnt  = 4'h0;
            next_rx_shift = 8'h00;
            next_state    = shlp_pkg::ST_CMD;
          end
        end
        shlp_pkg::ST_CMD: begin
          if (sclk_rise) begin
            if (bit_cnt == shlp_pkg::CMD_RW_BIT) begin
              next_rd_cmd = rx_bit;
            end else if (bit_cnt <= shlp_pkg::CMD_ADDR_LAST) begin
              if (lsb_mode) begin
                next_cmd_addr[3'(bit_cnt - 4'h1)] = rx_bit;
              end else begin
                next_cmd_addr[3'(shlp_pkg::CMD_ADDR_LAST - bit_cnt)] = rx_bit;
              end
            end
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == shlp_pkg::BYTE_LAST) begin
              next_bit_cnt  = 4'h0;
              next_reg_addr = cmd_addr;
              next_state    = shlp_pkg::ST_DATA;
            end
          end
        end
        shlp_pkg::ST_DATA: begin
          // read data launched on falling clock; input ignored on reads
          if (sclk_fall && rd_cmd) begin
            byte_out = (bit_cnt == 4'h0)
                     ? read_mux(ctrl[shlp_pkg::LOADER_EN_POS], cmd_addr,
                                ctrl, sig, reg_rdata_i)
                     : tx_shift;
            next_tx_bit   = lsb_mode ? byte_out[0] : byte_out[7];
            next_tx_shift = lsb_mode ? {1'b0, byte_out[7:1]} : {byte_out[6:0], 1'b0};
            next_tx_oe    = 1'b1;
          end
          if (sclk_rise) begin
            next_rx_shift = byte_in;
            next_bit_cnt  = bit_cnt + 4'h1;
            if (bit_cnt == shlp_pkg::BYTE_LAST) begin
              next_state = shlp_pkg::ST_WAIT;
              // reads fall through here and leave the loader alone
              if (!rd_cmd) begin
                if (cmd_addr == shlp_pkg::CTRL_ADDR) begin
                  next_ctrl = byte_in & shlp_pkg::CTRL_MASK;
                  if (!byte_in[shlp_pkg::LOADER_EN_POS]) begin
                    next_sig      = MISR_SEED;
                    next_fill_cnt = shlp_pkg::FILL_RESET;
                  end
                end else if (ctrl[shlp_pkg::LOADER_EN_POS]) begin
                  if (fill_cnt < shlp_pkg::RAM_DEPTH) begin
                    next_ram_we    = 1'b1;
                    next_ram_waddr = fill_cnt[11:0];
                    next_ram_wdata = byte_in;
                    next_fill_cnt  = fill_cnt + 13'h0001;
                    next_sig       = misr_step(sig, byte_in);
                  end
                end else begin
                  next_reg_wr    = 1'b1;
                  next_reg_wdata = byte_in;
                end
              end
            end
          end
        end
        shlp_pkg::ST_WAIT: begin
          next_state = shlp_pkg::ST_WAIT;
        end
        default: begin
          next_state = shlp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // state registers; reset holds the pin released and the loader ready
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state     <= shlp_pkg::ST_IDLE;
      lsb_mode  <= 1'b0;
      bit_cnt   <= 4'h0;
      rd_cmd    <= 1'b0;
      cmd_addr  <= 6'h00;
      rx_shift  <= 8'h00;
      tx_shift  <= 8'h00;
      tx_bit    <= 1'b0;
      tx_oe     <= 1'b0;
      ctrl      <= shlp_pkg::CTRL_RESET;
      sig       <= MISR_SEED;
      fill_cnt  <= shlp_pkg::FILL_RESET;
      reg_wr    <= 1'b0;
      reg_addr  <= 6'h00;
      reg_wdata <= 8'h00;
      ram_we    <= 1'b0;
      ram_waddr <= 12'h000;
      ram_wdata <= 8'h00;
    end else begin
      state     <= next_state;
      lsb_mode  <= next_lsb_mode;
      bit_cnt   <= next_bit_cnt;
      rd_cmd    <= next_rd_cmd;
      cmd_addr  <= next_cmd_addr;
      rx_shift  <= next_rx_shift;
      tx_shift  <= next_tx_shift;
      tx_bit    <= next_tx_bit;
      tx_oe     <= next_tx_oe;
      ctrl      <= next_ctrl;
      sig       <= next_sig;
      fill_cnt  <= next_fill_cnt;
      reg_wr    <= next_reg_wr;
      reg_addr  <= next_reg_addr;
      reg_wdata <= next_reg_wdata;
      ram_we    <= next_ram_we;
      ram_waddr <= next_ram_waddr;
      ram_wdata <= next_ram_wdata;
    end
  end

  // ram write port from the loader, read port for program fetch
  assign ram.we    = ram_we;
  assign ram.waddr = ram_waddr;
  assign ram.wdata = ram_wdata;
  assign ram.raddr = prog_addr_i;

  shlp_prog_ram u_ram (
    .clk_i (ref_clk_i),
    .ram   (ram.mem)
  );

  // outputs, each from a flip-flop
  assign shared_serial_io_o    = tx_bit;
  assign shared_serial_io_oe_o = tx_oe;
  assign reg_wr_o              = reg_wr;
  assign reg_addr_o            = reg_addr;
  assign reg_wdata_o           = reg_wdata;
  assign loader_enable_o       = ctrl[shlp_pkg::LOADER_EN_POS];
  assign ram_execute_select_o  = ctrl[shlp_pkg::RAM_EXEC_POS];
  assign prog_data_o           = ram.rdata;
endmodule
`default_nettype wire

// File: tb/shlp_serial_port_props.sv
// checker for the serial host port, watching only its top-level pins
// assumes ref_clk_i samples the serial pins and rst_b_i is active low
`timescale 1ns/1ps
`default_nettype none
module shlp_serial_port_props (
  input wire logic       ref_clk_i,
  input wire logic       rst_b_i,
  input wire logic       cs_b_i,
  input wire logic       sclk_i,
  input wire logic       shared_serial_io_o,
  input wire logic       shared_serial_io_oe_o,
  input wire logic       reg_wr_o,
  input wire logic [5:0] reg_addr_o,
  input wire logic       loader_enable_o,
  input wire logic       ram_execute_select_o
);
  logic       sclk_q;
  logic       cs_q;
  logic [4:0] rise_cnt;
  logic [4:0] next_rise_cnt;
  logic [3:0] fall_age;
  logic [3:0] next_fall_age;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  // raw clock rises since select fell, cycles since the last clock fall
  always_comb begin
    next_rise_cnt = rise_cnt;
    next_fall_age = (fall_age == 4'hF) ? fall_age : fall_age + 4'h1;
    if (cs_q && !cs_b_i) begin
      next_rise_cnt = 5'h00;
    end else if (!cs_b_i && sclk_i && !sclk_q && rise_cnt != 5'h1F) begin
      next_rise_cnt = rise_cnt + 5'h01;
    end
    if (sclk_q && !sclk_i) begin
      next_fall_age = 4'h0;
    end
  end
  // helper registers
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_q   <= 1'b0;
      cs_q     <= 1'b1;
      rise_cnt <= 5'h00;
      fall_age <= 4'hF;
    end else begin
      sclk_q   <= sclk_i;
      cs_q     <= cs_b_i;
      rise_cnt <= next_rise_cnt;
      fall_age <= next_fall_age;
    end
  end
  sequence s_select_idle;
    cs_b_i [*6];
  endsequence
  sequence s_frame_done;
    rise_cnt == 5'd16;
  endsequence
  property p_idle_release;
    s_select_idle |-> !shared_serial_io_oe_o;
  endproperty
  property p_reset_quiet;
    $rose(rst_b_i) |-> !shared_serial_io_oe_o && !reg_wr_o && !loader_enable_o
                       && !ram_execute_select_o;
  endproperty
  property p_drive_after_cmd;
    $rose(shared_serial_io_oe_o) |-> rise_cnt inside {5'd8, 5'd9};
  endproperty
  property p_launch_on_fall;
    $changed(shared_serial_io_o) && shared_serial_io_oe_o && $past(shared_serial_io_oe_o)
      |-> fall_age <= 4'd4;
  endproperty
  property p_wr_after_frame;
    reg_wr_o |-> s_frame_done;
  endproperty
  property p_wr_pulse;
    reg_wr_o |=> !reg_wr_o;
  endproperty
  property p_ctrl_after_frame;
    $changed({ram_execute_select_o, loader_enable_o}) |-> s_frame_done;
  endproperty
  property p_no_reg_wr_loader;
    reg_wr_o |-> !loader_enable_o && reg_addr_o != shlp_pkg::CTRL_ADDR;
  endproperty
  a_idle_release: assert property (p_idle_release)
    else $error("pin driven deselected");
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs busy at reset");
  a_drive_after_cmd: assert property (p_drive_after_cmd) else $error("early drive");
  a_launch_on_fall: assert property (p_launch_on_fall) else $error("bit not at fall");
  a_wr_after_frame: assert property (p_wr_after_frame) else $error("write mid frame");
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
  a_ctrl_after_frame: assert property (p_ctrl_after_frame)
    else $error("ctrl mid frame");
  a_no_reg_wr_loader: assert property (p_no_reg_wr_loader)
    else $error("stray write");
endmodule
bind shlp_serial_port shlp_serial_port_props u_props (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i), .sclk_i(sclk_i),
  .shared_serial_io_o(shared_serial_io_o), .shared_serial_io_oe_o(shared_serial_io_oe_o),
  .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o), .loader_enable_o(loader_enable_o),
  .ram_execute_select_o(ram_execute_select_o));
`default_nettype wire

// File: tb/shlp_host_model.sv
// host controller model: drives select, serial clock and data pins
// assumes one xfer call at a time, pins changed at ref_clk_i falls
`timescale 1ns/1ps
`default_nettype none
module shlp_host_model (
  input  wire logic ref_clk_i,
  input  wire logic sio_i,
  output var  logic cs_b_o,
  output var  logic sclk_o,
  output wire logic sio_o,
  output wire logic ded_o
);
  logic junk = 1'b0;
  logic drv_s;
  logic drv_d;
  logic bit_v;
  // released lines show a pattern that changes every cycle
  always @(negedge ref_clk_i) junk <= ~junk;
  assign sio_o = drv_s ? bit_v : junk;
  assign ded_o = drv_d ? bit_v : junk;
  initial begin
    cs_b_o = 1'b1;
    sclk_o = 1'b0;
    drv_s  = 1'b0;
    drv_d  = 1'b0;
    bit_v  = 1'b0;
  end
  // one two-byte transaction, either timing mode
  task automatic xfer(input logic lsb, input logic rd, input logic [5:0] a,
                      input logic [7:0] wd, output logic [7:0] rv);
    logic [15:0] seq;
    int          k;
    seq[0] = rd;
    seq[7] = 1'b0;
    for (k = 0; k < 6; k++) begin
      seq[1+k] = lsb ? a[k] : a[5-k];
    end
    for (k = 0; k < 8; k++) begin
      seq[8+k] = lsb ? wd[k] : wd[7-k];
    end
    rv = 8'h00;
    sclk_o = lsb; // clock level at select fall picks the mode
    repeat (4) @(negedge ref_clk_i);
    cs_b_o = 1'b0; // held low for both bytes
    repeat (4) @(negedge ref_clk_i);
    for (k = 0; k < 16; k++) begin
      if (lsb) sclk_o = 1'b0;
      bit_v = seq[k];
      drv_s = lsb && (k < 8 || !rd);
      drv_d = !lsb && (k < 8 || !rd);
      repeat (4) @(negedge ref_clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      if (k > 7 && rd) rv[lsb ? k - 8 : 15 - k] = sio_i;
      if (!lsb) sclk_o = 1'b0;
    end
    cs_b_o = 1'b1;
    drv_s = 1'b0;
    drv_d = 1'b0;
    repeat (10) @(negedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// File: tb/test_serial_host_port_with_ram_loader.sv
// self-checking bench for the serial host port and its ram loader
// assumes the host model drives the pins and the checker is bound in
`timescale 1ns/1ps
`default_nettype none
module test_serial_host_port_with_ram_loader;
  localparam logic [7:0] POLY = 8'h39;
  localparam logic [7:0] SEED = 8'h5C;
  logic        ref_clk_i, rst_b_i, cs_b, sclk, h_sio, ded, sio, dut_o, dut_oe;
  logic        reg_wr, ld_en, ram_ex;
  logic [5:0]  reg_addr, addr;
  logic [7:0]  reg_wdata, reg_rdata, prog_data, ctrl, sig;
  logic [11:0] prog_addr;
  logic [13:0] wr_q[$];
  logic [7:0]  ram_m[4096];
  int          fill, bad_count, check_count;
  // device output wins the shared line while enabled
  assign sio = dut_oe ? dut_o : h_sio;
  shlp_host_model host (.ref_clk_i(ref_clk_i), .sio_i(sio), .cs_b_o(cs_b), .sclk_o(sclk),
    .sio_o(h_sio), .ded_o(ded));
  shlp_serial_port #(.MISR_POLY(POLY), .MISR_SEED(SEED)) dut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .sclk_i(sclk),
    .shared_serial_io_i(sio), .shared_serial_io_o(dut_o), .shared_serial_io_oe_o(dut_oe),
    .dedicated_serial_in_i(ded), .reg_wr_o(reg_wr), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata), .loader_enable_o(ld_en),
    .ram_execute_select_o(ram_ex), .prog_addr_i(prog_addr), .prog_data_o(prog_data));
  // free-running clock, unrelated to the serial frames
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // collect every register write pulse
  always @(posedge ref_clk_i) if (reg_wr === 1'b1) wr_q.push_back({reg_addr, reg_wdata});
  // shared count and report behind every compare task
  task automatic tally(input logic ok, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (!ok) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // read data returned on the serial pin
  task automatic chk_read(input logic [7:0] got, input logic [7:0] exp);
    tally(got === exp, {8'h00, got}, {8'h00, exp});
  endtask
  // register write pulses: their count, then address and data
  task automatic chk_wr(input logic [15:0] got, input logic [15:0] exp);
    tally(got === exp, got, exp);
  endtask
  // ram execute and loader enable pins
  task automatic chk_pins(input logic [1:0] got, input logic [1:0] exp);
    tally(got === exp, {14'h0000, got}, {14'h0000, exp});
  endtask
  // program ram contents through the fetch port
  task automatic chk_mem(input logic [7:0] got, input logic [7:0] exp);
    tally(got === exp, {8'h00, got}, {8'h00, exp});
  endtask
  task automatic wrap_up;
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic [7:0] misr(input logic [7:0] s, input logic [7:0] d);
    return {s[6:0], 1'b0} ^ (s[7] ? POLY : 8'h00) ^ d;
  endfunction
  task automatic hw_reset;
    rst_b_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    ctrl = shlp_pkg::CTRL_RESET;
    sig  = SEED;
    fill = 0;
  endtask
  // one transaction, with the model updated and every result compared
  task automatic do_xfer(input logic lsb, input logic rd, input logic [5:0] a,
                         input logic [7:0] wd);
    logic [7:0] rv;
    logic [7:0] ex;
    logic       ld;
    ld = ctrl[shlp_pkg::LOADER_EN_POS];
    reg_rdata = 8'($urandom);
    wr_q.delete();
    host.xfer(lsb, rd, a, wd, rv);
    if (rd) begin
      ex = ld ? (a[5] ? ctrl : sig) : (a == shlp_pkg::CTRL_ADDR) ? ctrl
         : (a == shlp_pkg::SIG_ADDR) ? sig : reg_rdata;
      chk_read(rv, ex);
    end else if (a == shlp_pkg::CTRL_ADDR) begin
      ctrl = wd & shlp_pkg::CTRL_MASK;
      if (!ctrl[2]) begin
        sig  = SEED;
        fill = 0;
      end
    end else if (ld && fill < 4096) begin
      ram_m[fill] = wd;
      sig = misr(sig, wd);
      fill++;
    end
    chk_wr(16'(wr_q.size()), {15'h0000, !rd && !ld && a != shlp_pkg::CTRL_ADDR});
    if (wr_q.size() == 1) chk_wr({2'b00, wr_q[0]}, {2'b00, a, wd});
    chk_pins({ram_ex, ld_en}, ctrl[3:2]);
  endtask
  task automatic chk_ram;
    for (int i = 0; i < fill; i++) begin
      prog_addr = 12'(i);
      @(negedge ref_clk_i);
      chk_mem(prog_data, ram_m[i]);
    end
  endtask
  // bound on the whole run
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    bad_count++;
    wrap_up();
  end
  initial begin
    rst_b_i = 1'b0;
    reg_rdata = 8'h00;
    prog_addr = 12'h000;
    bad_count = 0;
    check_count = 0;
    void'($urandom(97));
    hw_reset();
    // plain register traffic in both timing modes
    for (int m = 0; m < 2; m++) begin
      do_xfer(m[0], 1'b1, shlp_pkg::CTRL_ADDR, 8'h00);
      do_xfer(m[0], 1'b1, shlp_pkg::SIG_ADDR, 8'h00);
      repeat (3) begin
        addr = 6'($urandom % 63);
        do_xfer(m[0], 1'b0, addr, 8'($urandom));
        do_xfer(m[0], 1'b1, addr, 8'h00);
      end
    end
    // load with fills, reads and a control write in between, rom kept selected
    do_xfer(1'b0, 1'b0, shlp_pkg::CTRL_ADDR, 8'hF4);
    for (int i = 0; i < 30; i++) begin
      if (i == 12) do_xfer(1'b1, 1'b0, shlp_pkg::CTRL_ADDR, 8'h04);
      do_xfer(1'($urandom), ($urandom % 3) == 0, 6'($urandom % 63), 8'($urandom));
    end
    chk_ram();
    do_xfer(1'b1, 1'b1, 6'h20, 8'h00);
    do_xfer(1'b0, 1'b1, 6'h1F, 8'h00);
    do_xfer(1'b0, 1'b0, shlp_pkg::CTRL_ADDR, 8'h08);
    do_xfer(1'b0, 1'b1, shlp_pkg::SIG_ADDR, 8'h00);
    // a fresh load starts at the first address, after exit and after reset
    for (int r = 0; r < 2; r++) begin
      do_xfer(1'b1, 1'b0, shlp_pkg::CTRL_ADDR, 8'h04);
      repeat (3) do_xfer(1'b0, 1'b0, 6'h11, 8'($urandom));
      chk_ram();
      hw_reset();
      do_xfer(1'b1, 1'b1, shlp_pkg::SIG_ADDR, 8'h00);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
